/* File: core/lpsc_pkg.sv */
// Purpose: constants and types of the low power state controller
// Assumes: 100 MHz bus clock, two logical cores sharing one stop-clock request
// Notes: pin and event vectors are kept active high inside the block
package lpsc_pkg;

	// ********************************
	// Sizes and timing
	// ********************************
	localparam int NUM_LCORE = 2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SG_DELAY_CYC = 20;
	localparam int STEP_SETTLE_NS = 100;
	localparam int STEP_SETTLE_CYC = (STEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] SG_WAIT_LAST = 5'(SG_DELAY_CYC - 2);
	localparam logic [4:0] STEP_CNT_LAST = 5'(STEP_SETTLE_CYC - 1);
	localparam logic [0:0] SBC_IDX_LAST = 1'(NUM_LCORE - 1);

	// ********************************
	// Pin and event positions
	// ********************************
	localparam int NUM_PINS = 7;
	localparam int PIN_STOP = 0;
	localparam int PIN_SMI = 1;
	localparam int PIN_LINT1 = 5;
	localparam int PIN_RESET = 6;
	localparam int NUM_EV = 6;
	localparam int EV_BUS_INIT_ERROR_N = 1;

	// ********************************
	// Voltage codes and reset values
	// ********************************
	localparam logic [5:0] VID_NOM_CODE = 6'h0e;
	localparam logic [5:0] VID_LOW_CODE = 6'h1c;
	localparam logic EHALT_EN_RESET = 1'b1;

	typedef enum logic [10:0] {
		ST_NORMAL = 11'h001,
		ST_SBC_ISSUE = 11'h002,
		ST_SBC_WAIT = 11'h004,
		ST_STOP_GRANT = 11'h008,
		ST_GRANT_SNOOP = 11'h010,
		ST_HALT = 11'h020,
		ST_HALT_SNOOP = 11'h040,
		ST_EH_ENTER = 11'h080,
		ST_EHALT = 11'h100,
		ST_EH_SNOOP = 11'h200,
		ST_EH_EXIT = 11'h400
	} lpsc_state_type;

	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_RATIO_DN = 5'h02,
		PH_VID_DN = 5'h04,
		PH_VID_UP = 5'h08,
		PH_RATIO_UP = 5'h10
	} lpsc_phase_type;

endpackage

/* File: core/lpsc_step_if.sv */
// Purpose: handshake between the state controller and the ratio/voltage stepper
// Assumes: one clock domain
// Notes: go is a one-cycle pulse, done answers it once the step has settled
`timescale 1ns/1ps
interface lpsc_step_if;
	logic go;
	logic raise;
	logic done;
	logic ratio_low;
	logic vid_low;

	modport ctrl (output go, output raise, input done, input ratio_low, input vid_low);
	modport step (input go, input raise, output done, output ratio_low, output vid_low);
endinterface

/* File: core/lpsc_ratio_vid.sv */
// Purpose: orders core ratio and voltage changes around Enhanced HALT
// Assumes: settle time per step is STEP_SETTLE_CYC bus clocks
// Notes: going down moves the ratio first, going up moves the voltage first
`timescale 1ns/1ps
module lpsc_ratio_vid
	import lpsc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	lpsc_step_if.step step
);

	typedef struct packed {
		lpsc_phase_type phase;
		logic [4:0] cnt;
		logic ratio_low;
		logic vid_low;
		logic done;
	} lpsc_step_state_type;

	localparam lpsc_step_state_type STEP_RESET = '{PH_IDLE, 5'h00, 1'b0, 1'b0, 1'b0};

	lpsc_step_state_type q;
	lpsc_step_state_type next_q;

	// ********************************
	// Step sequencer
	// ********************************
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.cnt = q.cnt + 5'h01;
		unique case (q.phase)
			PH_IDLE: begin
				next_q.cnt = 5'h00;
				if (step.go && !step.raise) begin
					next_q.ratio_low = 1'b1;
					next_q.phase = PH_RATIO_DN;
				end else if (step.go) begin
					next_q.vid_low = 1'b0;
					next_q.phase = PH_VID_UP;
				end
			end
			PH_RATIO_DN: begin
				if (q.cnt == STEP_CNT_LAST) begin
					next_q.vid_low = 1'b1;
					next_q.cnt = 5'h00;
					next_q.phase = PH_VID_DN;
				end
			end
			PH_VID_UP: begin
				if (q.cnt == STEP_CNT_LAST) begin
					next_q.ratio_low = 1'b0;
					next_q.cnt = 5'h00;
					next_q.phase = PH_RATIO_UP;
				end
			end
			PH_VID_DN, PH_RATIO_UP: begin
				if (q.cnt == STEP_CNT_LAST) begin
					next_q.done = 1'b1;
					next_q.phase = PH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			q <= STEP_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign step.done = q.done;
	assign step.ratio_low = q.ratio_low;
	assign step.vid_low = q.vid_low;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	ratio_before_vid_a: assert property ($rose(q.vid_low) |-> $past(q.ratio_low, 2))
		else $error("voltage lowered before the ratio");
	vid_before_ratio_a: assert property ($fell(q.ratio_low) |-> !q.vid_low && !$past(q.vid_low, 2))
		else $error("ratio restored before the voltage");

endmodule

/* File: core/lpsc_ctrl.sv */
// Purpose: power state controller for Normal, HALT, Enhanced HALT and Stop-Grant
// Assumes: pins are asynchronous; bus strobes come from logic on the bus clock
// Notes: latched events are released as one service pulse on return to Normal
`timescale 1ns/1ps
module lpsc_ctrl
	import lpsc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_stop_clock_request_n,
	input wire logic i_system_mgmt_irq_n,
	input wire logic i_bus_init_error_n,
	input wire logic i_soft_init_n,
	input wire logic [1:0] i_local_irq_pins,
	input wire logic i_core_reset_n,
	input wire logic [NUM_LCORE-1:0] i_core_halted,
	input wire logic i_at_min_ratio,
	input wire logic i_ehalt_cfg_we,
	input wire logic i_ehalt_cfg_val,
	input wire logic i_interrupt_enable_flag,
	input wire logic i_fsb_irq_msg,
	input wire logic i_bus_txn,
	input wire logic i_snoop_done,
	input wire logic i_sbc_resp,
	output logic o_special_bus_cycle_req,
	output logic [0:0] o_sbc_core,
	output logic [10:0] o_power_state,
	output logic o_core_clk_run,
	output logic o_pending_break_out_n,
	output logic [NUM_EV-1:0] o_event_service,
	output logic o_wake,
	output logic o_core_init,
	output logic o_core_ratio_low,
	output logic [5:0] o_voltage_id_code
);

	typedef struct packed {
		lpsc_state_type state;
		logic [NUM_PINS-1:0] s1;
		logic [NUM_PINS-1:0] s2;
		logic [NUM_PINS-1:0] s3;
		logic [NUM_EV-1:0] pending;
		logic [0:0] sbc_idx;
		logic [4:0] cnt;
		logic return_halt;
		logic ehalt_en;
		logic pbe_n;
		logic clk_run;
		logic [NUM_EV-1:0] svc;
		logic wake;
		logic core_init;
		logic step_go;
		logic step_raise;
	} lpsc_ctrl_state_type;

	localparam lpsc_ctrl_state_type CTRL_RESET = '{
		state: ST_NORMAL, s1: 7'h00, s2: 7'h00, s3: 7'h00, pending: 6'h00,
		sbc_idx: 1'h0, cnt: 5'h00, return_halt: 1'b0, ehalt_en: EHALT_EN_RESET,
		pbe_n: 1'b1, clk_run: 1'b1, svc: 6'h00, wake: 1'b0, core_init: 1'b0,
		step_go: 1'b0, step_raise: 1'b0
	};

	lpsc_ctrl_state_type q;
	lpsc_ctrl_state_type next_q;
	lpsc_step_if step_bus ();

	logic [NUM_PINS-1:0] pins_raw;
	logic [NUM_PINS-1:0] pin_edge;
	logic [NUM_EV-1:0] ev;
	logic stop_req;
	logic all_halted;
	logic any_ev;

	// Stop-Grant or its snoop sub-state
	function automatic logic in_grant(input lpsc_state_type s);
		in_grant = (s == ST_STOP_GRANT) || (s == ST_GRANT_SNOOP);
	endfunction

	// States in which break events are held instead of acted on at once
	function automatic logic holds_events(input lpsc_state_type s);
		holds_events = in_grant(s) || (s == ST_HALT_SNOOP) || (s == ST_EH_SNOOP)
			|| (s == ST_EH_ENTER) || (s == ST_EH_EXIT);
	endfunction

	function automatic logic clk_running(input lpsc_state_type s);
		clk_running = (s == ST_NORMAL) || (s == ST_SBC_ISSUE) || (s == ST_SBC_WAIT)
			|| (s == ST_EH_ENTER) || (s == ST_EH_EXIT);
	endfunction

	// ********************************
	// Pin conditioning
	// ********************************
	assign pins_raw = {~i_core_reset_n, i_local_irq_pins, ~i_soft_init_n,
		~i_bus_init_error_n, ~i_system_mgmt_irq_n, ~i_stop_clock_request_n};
	assign pin_edge = q.s2 & ~q.s3;
	assign stop_req = q.s2[PIN_STOP];
	assign ev = {i_fsb_irq_msg, pin_edge[PIN_LINT1:PIN_SMI]};
	assign any_ev = |ev;
	assign all_halted = &i_core_halted;

	// ********************************
	// State machine
	// ********************************
	always_comb begin
		next_q = q;
		next_q.s1 = pins_raw;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		next_q.svc = '0;
		next_q.wake = 1'b0;
		next_q.core_init = 1'b0;
		next_q.step_go = 1'b0;
		if (i_ehalt_cfg_we) begin
			next_q.ehalt_en = i_ehalt_cfg_val;
		end
		if (holds_events(q.state)) begin
			next_q.pending = q.pending | ev;
		end
		unique case (q.state)
			ST_NORMAL: begin
				if (stop_req) begin
					next_q.return_halt = 1'b0;
					next_q.sbc_idx = 1'h0;
					next_q.state = ST_SBC_ISSUE;
				end else if (all_halted && q.ehalt_en && !i_at_min_ratio) begin
					next_q.step_go = 1'b1;
					next_q.step_raise = 1'b0;
					next_q.state = ST_EH_ENTER;
				end else if (all_halted) begin
					next_q.state = ST_HALT;
				end
			end
			ST_SBC_ISSUE: begin
				if (i_sbc_resp && q.sbc_idx == SBC_IDX_LAST) begin
					next_q.cnt = 5'h00;
					next_q.state = ST_SBC_WAIT;
				end else if (i_sbc_resp) begin
					next_q.sbc_idx = q.sbc_idx + 1'h1;
				end
			end
			ST_SBC_WAIT: begin
				next_q.cnt = q.cnt + 5'h01;
				if (q.cnt == SG_WAIT_LAST) begin
					next_q.state = ST_STOP_GRANT;
				end
			end
			ST_STOP_GRANT: begin
				if (!stop_req && q.return_halt && !(|next_q.pending)) begin
					next_q.state = ST_HALT;
				end else if (!stop_req) begin
					next_q.state = ST_NORMAL;
				end else if (i_bus_txn) begin
					next_q.state = ST_GRANT_SNOOP;
				end
			end
			ST_GRANT_SNOOP: begin
				if (i_snoop_done || i_fsb_irq_msg) begin
					next_q.state = ST_STOP_GRANT;
				end
			end
			ST_HALT: begin
				if (stop_req) begin
					next_q.return_halt = 1'b1;
					next_q.sbc_idx = 1'h0;
					next_q.state = ST_SBC_ISSUE;
				end else if (any_ev || (|q.pending)) begin
					next_q.state = ST_NORMAL;
				end else if (i_bus_txn) begin
					next_q.state = ST_HALT_SNOOP;
				end
			end
			ST_HALT_SNOOP: begin
				if (i_snoop_done || i_fsb_irq_msg) begin
					next_q.state = ST_HALT;
				end
			end
			ST_EH_ENTER: begin
				if (step_bus.done) begin
					next_q.state = ST_EHALT;
				end
			end
			ST_EHALT: begin
				if (stop_req || any_ev || (|q.pending)) begin
					next_q.step_go = 1'b1;
					next_q.step_raise = 1'b1;
					next_q.pending = q.pending | ev;
					next_q.state = ST_EH_EXIT;
				end else if (i_bus_txn) begin
					next_q.state = ST_EH_SNOOP;
				end
			end
			ST_EH_SNOOP: begin
				if (i_snoop_done || i_fsb_irq_msg) begin
					next_q.state = ST_EHALT;
				end
			end
			ST_EH_EXIT: begin
				if (step_bus.done) begin
					next_q.state = ST_NORMAL;
				end
			end
		endcase
		// A core reset in Stop-Grant initialises without leaving the state
		if (pin_edge[PIN_RESET]) begin
			next_q.core_init = 1'b1;
			if (q.state == ST_HALT || q.state == ST_HALT_SNOOP) begin
				next_q.state = ST_NORMAL;
			end
		end
		if (next_q.state == ST_NORMAL && q.state != ST_NORMAL) begin
			next_q.svc = next_q.pending | ev;
			next_q.pending = '0;
			next_q.wake = 1'b1;
		end
		// Masked interrupts count as pending as well
		next_q.pbe_n = !(in_grant(next_q.state) && (|next_q.pending));
		next_q.clk_run = clk_running(next_q.state);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			q <= CTRL_RESET;
		end else begin
			q <= next_q;
		end
	end

	// ********************************
	// Stepper and outputs
	// ********************************
	assign step_bus.go = q.step_go;
	assign step_bus.raise = q.step_raise;

	lpsc_ratio_vid u_ratio_vid (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.step(step_bus)
	);

	assign o_special_bus_cycle_req = (q.state == ST_SBC_ISSUE);
	assign o_sbc_core = q.sbc_idx;
	assign o_power_state = q.state;
	assign o_core_clk_run = q.clk_run;
	assign o_pending_break_out_n = q.pbe_n;
	assign o_event_service = q.svc;
	assign o_wake = q.wake;
	assign o_core_init = q.core_init;
	assign o_core_ratio_low = step_bus.ratio_low;
	assign o_voltage_id_code = step_bus.vid_low ? VID_LOW_CODE : VID_NOM_CODE;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	sequence last_ack_s;
		q.state == ST_SBC_ISSUE && i_sbc_resp && q.sbc_idx == SBC_IDX_LAST;
	endsequence

	sequence grant_after_wait_s;
		##19 (q.state == ST_SBC_WAIT) ##1 (q.state == ST_STOP_GRANT);
	endsequence

	sbc_per_core_a: assert property (
		(q.state == ST_SBC_ISSUE && i_sbc_resp && q.sbc_idx != SBC_IDX_LAST)
		|=> o_special_bus_cycle_req && o_sbc_core == $past(q.sbc_idx) + 1'h1)
		else $error("acknowledge cycle not issued for every core");
	grant_delay_a: assert property (last_ack_s |-> grant_after_wait_s)
		else $error("Stop-Grant not reached 20 clocks after acknowledge");
	halt_all_cores_a: assert property (
		(q.state == ST_NORMAL && !all_halted) |=> q.state != ST_HALT && q.state != ST_EH_ENTER)
		else $error("halt entered with a core still running");
	halt_wake_a: assert property (
		(q.state == ST_HALT && !stop_req && any_ev && !pin_edge[PIN_RESET])
		|=> q.state == ST_NORMAL && o_wake)
		else $error("break event did not wake from HALT");
	grant_reset_stays_a: assert property (
		(q.state == ST_STOP_GRANT && stop_req && pin_edge[PIN_RESET])
		|=> o_core_init && in_grant(q.state))
		else $error("reset left Stop-Grant");
	grant_to_halt_a: assert property (
		(q.state == ST_STOP_GRANT && !stop_req && q.return_halt && !(|q.pending) && !any_ev)
		|=> q.state == ST_HALT)
		else $error("stop release did not return to HALT");
	ehalt_default_a: assert property ($fell(i_srst) |-> q.ehalt_en)
		else $error("Enhanced HALT not enabled after reset");
	min_ratio_halt_a: assert property (
		(q.state == ST_NORMAL && all_halted && i_at_min_ratio && !stop_req)
		|=> q.state == ST_HALT)
		else $error("lowest ratio halt did not use plain HALT");
	event_service_a: assert property (
		(q.state == ST_STOP_GRANT && !stop_req && (q.return_halt == 1'b0))
		|=> q.state == ST_NORMAL && o_event_service == ($past(q.pending) | $past(ev))
		&& q.pending == '0)
		else $error("latched events not released on return to Normal");
	pending_break_a: assert property (
		(in_grant(q.state) && (|q.pending)) |-> !o_pending_break_out_n)
		else $error("pending-break not asserted for a latched interrupt");
	snoop_return_a: assert property (
		(q.state == ST_HALT && !stop_req && !any_ev && !(|q.pending) && i_bus_txn
			&& !pin_edge[PIN_RESET])
		##1 (i_snoop_done && !pin_edge[PIN_RESET]) |=> q.state == ST_HALT)
		else $error("halt snoop did not return to HALT");
	eh_snoop_keep_a: assert property (
		(q.state == ST_EH_SNOOP) |-> o_core_ratio_low && o_voltage_id_code == VID_LOW_CODE)
		else $error("Enhanced snoop left the reduced operating point");

	// ********************************
	// Sub-state and latch checks
	// ********************************
	masked_break_a: assert property (
		(in_grant(q.state) && (|q.pending) && !i_interrupt_enable_flag) |-> !o_pending_break_out_n)
		else $error("pending-break dropped for a masked interrupt");
	grant_clock_stop_a: assert property (in_grant(q.state) |-> !o_core_clk_run)
		else $error("core clocks running in Stop-Grant");
	sbc_hold_a: assert property (
		(q.state == ST_SBC_ISSUE && !i_sbc_resp) |=> o_special_bus_cycle_req && $stable(o_sbc_core))
		else $error("acknowledge cycle dropped before its response");
	grant_latch_a: assert property (
		(in_grant(q.state) && stop_req && ev[EV_BUS_INIT_ERROR_N]) |=> q.pending[EV_BUS_INIT_ERROR_N])
		else $error("bus-init error not latched in Stop-Grant");
	grant_snoop_hold_a: assert property (
		(q.state == ST_GRANT_SNOOP && !i_snoop_done && !i_fsb_irq_msg)
		|=> q.state == ST_GRANT_SNOOP)
		else $error("grant snoop left before the snoop was serviced");
	grant_snoop_back_a: assert property (
		(q.state == ST_GRANT_SNOOP && (i_snoop_done || i_fsb_irq_msg))
		|=> q.state == ST_STOP_GRANT)
		else $error("grant snoop did not return to Stop-Grant");
	halt_snoop_irq_a: assert property (
		(q.state == ST_HALT_SNOOP && i_fsb_irq_msg && !pin_edge[PIN_RESET])
		|=> q.state == ST_HALT && q.pending[NUM_EV-1])
		else $error("halt snoop did not latch the bus interrupt");
	ehalt_exit_step_a: assert property (
		(q.state == ST_EHALT && any_ev) |=> q.state == ST_EH_EXIT)
		else $error("break event did not start the Enhanced HALT exit");
	eh_snoop_back_a: assert property (
		(q.state == ST_EH_SNOOP && i_snoop_done) |=> q.state == ST_EHALT)
		else $error("Enhanced snoop did not return to Enhanced HALT");
	ehalt_off_halt_a: assert property (
		(q.state == ST_NORMAL && all_halted && !q.ehalt_en && !stop_req)
		|=> q.state == ST_HALT)
		else $error("disabled Enhanced HALT did not use plain HALT");

endmodule

/* File: tb/lpsc_chipset_model.sv */
// Purpose: chipset side of the stop-clock and acknowledge handshake
// Assumes: outputs change at the falling edge of the bus clock
// Notes: each acknowledge cycle is answered after i_resp_delay clocks
`timescale 1ns/1ps
module lpsc_chipset_model (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_stop_cmd,
	input wire logic i_break_release,
	input wire logic [3:0] i_resp_delay,
	input wire logic i_sbc_req,
	input wire logic i_pending_break_out_n,
	input wire logic [10:0] i_power_state,
	output logic o_stop_clock_request_n,
	output logic o_sbc_resp
);
	logic active = 1'b0;
	logic granted = 1'b0;
	logic cmd_prev = 1'b0;
	logic [3:0] cnt = 4'h0;
	assign o_stop_clock_request_n = ~active;
	always @(negedge i_clk_sys) begin
		cmd_prev <= i_stop_cmd;
		if (i_srst) begin
			active <= 1'b0;
			granted <= 1'b0;
			cnt <= 4'h0;
			o_sbc_resp <= 1'b0;
		end else begin
			// One response per acknowledge cycle, any number of them
			if (o_sbc_resp) begin
				o_sbc_resp <= 1'b0;
			end else if (i_sbc_req && cnt == i_resp_delay) begin
				o_sbc_resp <= 1'b1;
				cnt <= 4'h0;
			end else if (i_sbc_req) begin
				cnt <= cnt + 4'h1;
			end else begin
				cnt <= 4'h0;
			end
			if (i_stop_cmd && !cmd_prev) begin
				active <= 1'b1;
			end
			if (i_power_state == 11'h008) begin
				granted <= 1'b1;
			end
			// Held until Stop-Grant, pending break asks for release
			if (active && granted && (!i_stop_cmd || (i_break_release && !i_pending_break_out_n))) begin
				active <= 1'b0;
				granted <= 1'b0;
			end
		end
	end
endmodule

/* File: tb/tb_lpsc_ctrl.sv */
// Purpose: self-checking bench of the power state controller
// Assumes: chipset model answers acknowledge cycles
// Notes: inputs change at the falling edge, outputs read 2 ns after the rising edge
`timescale 1ns/1ps
module tb_lpsc_ctrl;
	import lpsc_pkg::*;
	logic clk = 0, srst = 1, stop_cmd = 0, brk_en = 0, smi_n = 1, bus_init_error_n_n = 1, sinit_n = 1;
	logic rst_n = 1, min = 0, cfg_we = 0, cfg_val = 1, ief = 0, fsb = 0, txn = 0, sdone = 0;
	logic stop_n, resp, req, run, pbe_n, wake, cinit, rlow;
	logic [1:0] lint = 0, halted = 0;
	logic [3:0] dly = 0;
	logic [0:0] core;
	logic [10:0] st;
	logic [5:0] svc, vid;
	int errors = 0, checked = 0, cycles = 0;

	lpsc_ctrl lpsc_ctrl_i (.i_clk_sys(clk), .i_srst(srst), .i_stop_clock_request_n(stop_n),
		.i_system_mgmt_irq_n(smi_n), .i_bus_init_error_n(bus_init_error_n_n), .i_soft_init_n(sinit_n),
		.i_local_irq_pins(lint), .i_core_reset_n(rst_n), .i_core_halted(halted),
		.i_at_min_ratio(min), .i_ehalt_cfg_we(cfg_we), .i_ehalt_cfg_val(cfg_val),
		.i_interrupt_enable_flag(ief), .i_fsb_irq_msg(fsb), .i_bus_txn(txn),
		.i_snoop_done(sdone), .i_sbc_resp(resp), .o_special_bus_cycle_req(req),
		.o_sbc_core(core), .o_power_state(st), .o_core_clk_run(run),
		.o_pending_break_out_n(pbe_n), .o_event_service(svc), .o_wake(wake),
		.o_core_init(cinit), .o_core_ratio_low(rlow), .o_voltage_id_code(vid));
	lpsc_chipset_model lpsc_chipset_model_i (.i_clk_sys(clk), .i_srst(srst),
		.i_stop_cmd(stop_cmd), .i_break_release(brk_en), .i_resp_delay(dly), .i_sbc_req(req),
		.i_pending_break_out_n(pbe_n), .i_power_state(st), .o_stop_clock_request_n(stop_n),
		.o_sbc_resp(resp));

	// ********************************
	// Helpers
	// ********************************
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic pulse(ref logic p, input logic act, input int len);
		@(negedge clk);
		p = act;
		repeat (len) @(negedge clk);
		p = ~act;
	endtask
	task automatic wait_st(input logic [10:0] exp, input int lim);
		int k;
		k = 0;
		while (st !== exp && k < lim) begin
			tick();
			k++;
		end
		chk(st, exp, "state");
	endtask
	// Flags voltage low while the ratio is back at full
	task automatic watch(input logic [10:0] exp, output logic bad);
		int k;
		bad = 1'b0;
		k = 0;
		while (st !== exp && k < 60) begin
			if (vid === VID_LOW_CODE && rlow === 1'b0) bad = 1'b1;
			tick();
			k++;
		end
		chk(st, exp, "state");
	endtask
	task automatic enter_sg;
		int n;
		logic [1:0] seen;
		@(negedge clk);
		stop_cmd <= 1'b1;
		seen = 2'b00;
		n = 0;
		wait_st(11'h002, 10);
		while (st !== 11'h008 && n < 200) begin
			if (req === 1'b1) begin
				seen[core] = 1'b1;
				n = 0;
			end
			tick();
			n++;
		end
		chk(seen, 2'b11, "one acknowledge per core");
		chk(n, SG_DELAY_CYC, "grant delay");
		chk(run, 1'b0, "core clocks stopped");
	endtask
	task automatic leave_sg(input logic [10:0] exp);
		@(negedge clk);
		stop_cmd <= 1'b0;
		wait_st(exp, 20);
		if (exp == 11'h001) chk(wake, 1'b1, "wake pulse");
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset;
		chk(st, 11'h001, "reset state");
		chk({run, pbe_n, rlow}, 3'b110, "reset levels");
		chk(vid, VID_NOM_CODE, "reset voltage");
		$display("test reset done");
	endtask
	task automatic t_stop;
		dly = 4'h5;
		enter_sg();
		pulse(txn, 1'b1, 1);
		wait_st(11'h010, 4);
		pulse(sdone, 1'b1, 1);
		wait_st(11'h008, 4);
		chk(pbe_n, 1'b1, "no break pending");
		leave_sg(11'h001);
		chk(svc, 6'h00, "nothing to service");
		$display("test stop_grant done");
	endtask
	task automatic t_events;
		dly = 4'h0;
		enter_sg();
		pulse(bus_init_error_n_n, 1'b0, 4);
		pulse(bus_init_error_n_n, 1'b0, 4);
		pulse(smi_n, 1'b0, 4);
		pulse(fsb, 1'b1, 1);
		tick(4);
		chk(st, 11'h008, "events held");
		chk(pbe_n, 1'b0, "break pending, flag clear");
		@(negedge clk);
		brk_en <= 1'b1;
		wait_st(11'h001, 20);
		chk(svc, 6'h23, "latched events serviced");
		tick();
		chk(svc, 6'h00, "service once");
		@(negedge clk);
		brk_en <= 1'b0;
		stop_cmd <= 1'b0;
		$display("test latched_events done");
	endtask
	task automatic t_halt;
		min = 1'b1;
		@(negedge clk);
		halted = 2'b01;
		tick(4);
		chk(st, 11'h001, "one core halted");
		@(negedge clk);
		halted = 2'b11;
		wait_st(11'h020, 4);
		chk(rlow, 1'b0, "ratio kept at minimum");
		pulse(txn, 1'b1, 1);
		wait_st(11'h040, 4);
		pulse(sdone, 1'b1, 1);
		wait_st(11'h020, 4);
		enter_sg();
		leave_sg(11'h020);
		@(negedge clk);
		lint = 2'b10;
		wait_st(11'h001, 10);
		@(negedge clk);
		lint = 2'b00;
		halted = 2'b00;
		min = 1'b0;
		$display("test halt done");
	endtask
	task automatic t_ehalt;
		logic bad;
		@(negedge clk);
		halted = 2'b11;
		wait_st(11'h080, 4);
		watch(11'h100, bad);
		chk(bad, 1'b0, "ratio lowered first");
		chk({rlow, vid}, {1'b1, VID_LOW_CODE}, "reduced point");
		pulse(txn, 1'b1, 1);
		wait_st(11'h200, 4);
		chk({rlow, vid}, {1'b1, VID_LOW_CODE}, "snoop keeps point");
		pulse(sdone, 1'b1, 1);
		wait_st(11'h100, 4);
		pulse(smi_n, 1'b0, 1);
		watch(11'h001, bad);
		@(negedge clk);
		halted = 2'b00;
		chk(bad, 1'b0, "voltage restored first");
		chk({rlow, vid}, {1'b0, VID_NOM_CODE}, "full point");
		$display("test enhanced_halt done");
	endtask
	task automatic t_ehalt_off;
		cfg_val = 1'b0;
		pulse(cfg_we, 1'b1, 1);
		@(negedge clk);
		halted = 2'b11;
		wait_st(11'h020, 4);
		pulse(txn, 1'b1, 1);
		wait_st(11'h040, 4);
		pulse(sdone, 1'b1, 1);
		wait_st(11'h020, 4);
		pulse(txn, 1'b1, 1);
		wait_st(11'h040, 4);
		pulse(fsb, 1'b1, 1);
		wait_st(11'h001, 4);
		chk(svc, 6'h20, "bus interrupt taken in halt");
		pulse(sinit_n, 1'b0, 1);
		wait_st(11'h001, 10);
		@(negedge clk);
		halted = 2'b00;
		cfg_val = 1'b1;
		pulse(cfg_we, 1'b1, 1);
		$display("test halt_disabled done");
	endtask
	task automatic t_reset_sg;
		logic got;
		got = 1'b0;
		enter_sg();
		pulse(rst_n, 1'b0, 1);
		repeat (6) begin
			tick();
			if (cinit === 1'b1) got = 1'b1;
		end
		chk(got, 1'b1, "cores initialised");
		chk(st, 11'h008, "stays granted");
		leave_sg(11'h001);
		$display("test reset_in_grant done");
	endtask

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			$display("[FAIL] %0t run too long", $time);
			wrap_up();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		tick();
		t_reset();
		t_stop();
		t_events();
		t_halt();
		t_ehalt();
		t_ehalt_off();
		t_reset_sg();
		wrap_up();
	end
endmodule
